// [hdl/sbs_pkg.sv]
package sbs_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [9:0] SBS_IDX_FAULT = 10'h10c;
  localparam logic [9:0] SBS_IDX_LINE = 10'h11b;
  localparam logic [9:0] SBS_IDX_CNT_A = 10'h11c;
  localparam logic [9:0] SBS_IDX_CNT_B = 10'h11d;
  localparam logic [9:0] SBS_IDX_CTRL_A = 10'h120;
  localparam logic [9:0] SBS_IDX_CTRL_B = 10'h121;

  // ----------------------------------------------------------------
  // Serial error word layout (port B sits one byte higher)
  // ----------------------------------------------------------------
  localparam int SBS_CODE_LSB = 0;
  localparam int SBS_ERR_BIT = 4;
  localparam int SBS_SEND_RDY_BIT = 5;
  localparam int SBS_RX_DONE_BIT = 6;
  localparam int SBS_OVF_BIT = 7;
  localparam int SBS_PORT_B_SHIFT = 8;

  // ----------------------------------------------------------------
  // Board fault word layout
  // ----------------------------------------------------------------
  localparam int SBS_F_HW_BIT = 0;
  localparam int SBS_F_RECOG_BIT = 1;
  localparam int SBS_F_CKSUM_BIT = 2;
  localparam int SBS_F_CALL_B_BIT = 11;
  localparam int SBS_F_CALL_A_BIT = 12;
  localparam int SBS_F_SET_B_BIT = 13;
  localparam int SBS_F_SET_A_BIT = 14;
  localparam int SBS_F_SET_BIT = 15;

  // ----------------------------------------------------------------
  // Port control word layout and reset values
  // ----------------------------------------------------------------
  localparam int SBS_CTRL_MODE_LSB = 0;
  localparam int SBS_CTRL_RESTART_BIT = 4;
  localparam int SBS_CTRL_END_LSB = 8;
  localparam logic [7:0] SBS_END_CNT_RST = 8'h00;
  localparam logic [8:0] SBS_END_CNT_FULL = 9'h100;
  localparam logic [15:0] SBS_WORD_RST = 16'h0000;
  localparam logic [31:0] SBS_RDATA_RST = 32'h0000_0000;

  typedef enum logic [2:0] {
    SBS_MODE_HOST_CMD = 3'b000,
    SBS_MODE_RAW = 3'b001,
    SBS_MODE_SCRIPT = 3'b010,
    SBS_MODE_LINK_1TO1 = 3'b011,
    SBS_MODE_MULTI_TERM = 3'b100
  } sbs_mode_t;

  typedef enum logic [3:0] {
    SBS_LERR_NONE = 4'h0,
    SBS_LERR_PARITY = 4'h1,
    SBS_LERR_FRAMING = 4'h2,
    SBS_LERR_OVERRUN = 4'h3,
    SBS_LERR_TIMEOUT = 4'h4
  } sbs_lerr_t;

  // Status sources of one serial port
  typedef struct packed {
    logic line_err_stb;
    logic [3:0] line_err_code;
    logic send_ready;
    logic rx_byte;
    logic seq_abort;
    logic [7:0] term_busy;
    logic [7:0] repeat_cnt;
  } sbs_port_in_t;

  // Board-level fault sources
  typedef struct packed {
    logic hw_err;
    logic recog_err;
    logic cksum_err;
    logic call_err_a;
    logic call_err_b;
    logic set_err_a;
    logic set_err_b;
  } sbs_board_in_t;

  typedef struct packed {
    logic [2:0] mode;
    logic [7:0] end_cnt;
    logic [3:0] code;
    logic [15:0] rx_cnt;
    logic done;
    logic ovf;
    logic abort;
  } sbs_port_st_t;

  typedef struct packed {
    logic wr_pend;
    logic [9:0] wr_idx;
    logic [31:0] rdata;
    logic [15:0] fault;
    sbs_port_st_t [1:0] port;
  } sbs_state_t;

endpackage

// [hdl/sbs_status_bank.sv]
// The AHB-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
module sbs_status_bank
  import sbs_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire sbs_port_in_t port_in [2],
  input wire sbs_board_in_t board_in,
  output logic [2:0] port_mode [2]
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  sbs_state_t st_r;
  sbs_state_t st_nxt;
  logic addr_ok;
  logic [9:0] addr_idx;
  logic [15:0] line_word;
  logic [15:0] cnt_word [2];
  logic [15:0] rd_word;

  assign addr_idx = haddr[11:2];
  // Active transfers of any size on mapped upper bits only
  assign addr_ok = hsel && htrans[1] && hready && (haddr[31:12] == 20'h00000);

  // ----------------------------------------------------------------
  // Status word assembly
  // ----------------------------------------------------------------
  always_comb begin
    line_word = SBS_WORD_RST;
    for (int p = 0; p < 2; p++) begin
      line_word[p*SBS_PORT_B_SHIFT+SBS_CODE_LSB +: 4] = st_r.port[p].code;
      line_word[p*SBS_PORT_B_SHIFT+SBS_ERR_BIT] = (st_r.port[p].code != SBS_LERR_NONE);
      if (st_r.port[p].mode == SBS_MODE_HOST_CMD || st_r.port[p].mode == SBS_MODE_RAW) begin
        line_word[p*SBS_PORT_B_SHIFT+SBS_SEND_RDY_BIT] = port_in[p].send_ready;
      end
      if (st_r.port[p].mode == SBS_MODE_RAW) begin
        line_word[p*SBS_PORT_B_SHIFT+SBS_RX_DONE_BIT] = st_r.port[p].done;
        line_word[p*SBS_PORT_B_SHIFT+SBS_OVF_BIT] = st_r.port[p].ovf;
      end else if (st_r.port[p].mode == SBS_MODE_SCRIPT) begin
        line_word[p*SBS_PORT_B_SHIFT+SBS_OVF_BIT] = st_r.port[p].abort;
      end
    end
  end

  // Counter words follow each port's mode
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      cnt_word[p] = SBS_WORD_RST;
      unique case (st_r.port[p].mode)
        SBS_MODE_MULTI_TERM: cnt_word[p][7:0] = port_in[p].term_busy;
        SBS_MODE_SCRIPT: cnt_word[p][7:0] = port_in[p].repeat_cnt;
        SBS_MODE_RAW: cnt_word[p] = st_r.port[p].rx_cnt;
        default: cnt_word[p] = SBS_WORD_RST;
      endcase
    end
  end

  // Read decode; unmapped reads give zero
  always_comb begin
    unique case (addr_idx)
      SBS_IDX_FAULT: rd_word = st_r.fault;
      SBS_IDX_LINE: rd_word = line_word;
      SBS_IDX_CNT_A: rd_word = cnt_word[0];
      SBS_IDX_CNT_B: rd_word = cnt_word[1];
      SBS_IDX_CTRL_A: rd_word = {st_r.port[0].end_cnt, 5'h00, st_r.port[0].mode};
      SBS_IDX_CTRL_B: rd_word = {st_r.port[1].end_cnt, 5'h00, st_r.port[1].mode};
      default: rd_word = SBS_WORD_RST;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic restart;
    logic [15:0] cnt_inc;
    logic [8:0] target;
    restart = 1'b0;
    cnt_inc = 16'h0000;
    target = 9'h000;
    st_nxt = st_r;
    // Address phase capture; read data ready in the data phase
    st_nxt.wr_pend = addr_ok && hwrite;
    st_nxt.wr_idx = addr_idx;
    st_nxt.rdata = addr_ok && !hwrite ? {16'h0000, rd_word} : st_r.rdata;
    // Board faults; reserved bits stay zero
    st_nxt.fault = SBS_WORD_RST;
    st_nxt.fault[SBS_F_HW_BIT] = board_in.hw_err;
    st_nxt.fault[SBS_F_RECOG_BIT] = board_in.recog_err;
    st_nxt.fault[SBS_F_CKSUM_BIT] = board_in.cksum_err;
    st_nxt.fault[SBS_F_CALL_A_BIT] = board_in.call_err_a;
    st_nxt.fault[SBS_F_CALL_B_BIT] = board_in.call_err_b;
    st_nxt.fault[SBS_F_SET_A_BIT] = board_in.set_err_a;
    st_nxt.fault[SBS_F_SET_B_BIT] = board_in.set_err_b;
    st_nxt.fault[SBS_F_SET_BIT] = board_in.set_err_a | board_in.set_err_b;
    for (int p = 0; p < 2; p++) begin
      // Control write; status words ignore writes
      restart = 1'b0;
      if (st_r.wr_pend && st_r.wr_idx == (p == 0 ? SBS_IDX_CTRL_A : SBS_IDX_CTRL_B)) begin
        st_nxt.port[p].mode = hwdata[SBS_CTRL_MODE_LSB +: 3];
        st_nxt.port[p].end_cnt = hwdata[SBS_CTRL_END_LSB +: 8];
        restart = hwdata[SBS_CTRL_RESTART_BIT];
      end
      // Restart clears first so a same-cycle event wins
      if (restart) begin
        st_nxt.port[p].code = SBS_LERR_NONE;
        st_nxt.port[p].rx_cnt = SBS_WORD_RST;
        st_nxt.port[p].done = 1'b0;
        st_nxt.port[p].ovf = 1'b0;
        st_nxt.port[p].abort = 1'b0;
      end
      // Line errors; timeout only in one-to-one link mode
      if (port_in[p].line_err_stb &&
          (port_in[p].line_err_code != SBS_LERR_TIMEOUT ||
           st_r.port[p].mode == SBS_MODE_LINK_1TO1)) begin
        st_nxt.port[p].code = port_in[p].line_err_code;
      end
      // Raw byte counting against the end count, zero meaning full
      target = (st_r.port[p].end_cnt == 8'h00) ? SBS_END_CNT_FULL
                                               : {1'b0, st_r.port[p].end_cnt};
      cnt_inc = (restart ? SBS_WORD_RST : st_r.port[p].rx_cnt) + 16'h0001;
      if (st_r.port[p].mode == SBS_MODE_RAW && port_in[p].rx_byte) begin
        if (st_r.port[p].done && !restart) begin
          st_nxt.port[p].ovf = 1'b1;
        end else begin
          st_nxt.port[p].rx_cnt = cnt_inc;
          if (cnt_inc == {7'h00, target}) begin
            st_nxt.port[p].done = 1'b1;
          end
        end
      end
      if (st_r.port[p].mode == SBS_MODE_SCRIPT && port_in[p].seq_abort) begin
        st_nxt.port[p].abort = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r.wr_pend <= 1'b0;
      st_r.wr_idx <= 10'h000;
      st_r.rdata <= SBS_RDATA_RST;
      st_r.fault <= SBS_WORD_RST;
      for (int p = 0; p < 2; p++) begin
        st_r.port[p].mode <= SBS_MODE_HOST_CMD;
        st_r.port[p].end_cnt <= SBS_END_CNT_RST;
        st_r.port[p].code <= SBS_LERR_NONE;
        st_r.port[p].rx_cnt <= SBS_WORD_RST;
        st_r.port[p].done <= 1'b0;
        st_r.port[p].ovf <= 1'b0;
        st_r.port[p].abort <= 1'b0;
      end
    end else begin
      st_r <= st_nxt;
    end
  end

  // Bus answers: zero wait, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st_r.rdata;
  assign port_mode[0] = st_r.port[0].mode;
  assign port_mode[1] = st_r.port[1].mode;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Read request taken this cycle
  logic rd_take;
  assign rd_take = addr_ok && !hwrite;

  // Line error codes and error flags
  err_flag_a_a: assert property (port_in[0].line_err_stb &&
      port_in[0].line_err_code inside {SBS_LERR_PARITY, SBS_LERR_FRAMING, SBS_LERR_OVERRUN}
      |=> line_word[SBS_ERR_BIT])
    else $error("port A error flag not raised");
  err_flag_b_a: assert property (port_in[1].line_err_stb &&
      port_in[1].line_err_code inside {SBS_LERR_PARITY, SBS_LERR_FRAMING, SBS_LERR_OVERRUN}
      |=> line_word[SBS_PORT_B_SHIFT+SBS_ERR_BIT])
    else $error("port B error flag not raised");
  err_clear_a: assert property (port_in[0].line_err_stb &&
      port_in[0].line_err_code == SBS_LERR_NONE |=> !line_word[SBS_ERR_BIT])
    else $error("port A error flag stuck");
  code_a_a: assert property (port_in[0].line_err_stb &&
      port_in[0].line_err_code != SBS_LERR_TIMEOUT
      |=> line_word[SBS_CODE_LSB +: 4] == $past(port_in[0].line_err_code))
    else $error("port A code not latched");
  code_b_a: assert property (port_in[1].line_err_stb &&
      port_in[1].line_err_code == SBS_LERR_PARITY |=> st_r.port[1].code == SBS_LERR_PARITY)
    else $error("port B parity code not latched");
  timeout_mode_a: assert property (port_in[0].line_err_stb &&
      port_in[0].line_err_code == SBS_LERR_TIMEOUT &&
      st_r.port[0].mode != SBS_MODE_LINK_1TO1 && !st_r.wr_pend
      |=> st_r.port[0].code == $past(st_r.port[0].code))
    else $error("timeout code taken outside one-to-one mode");
  timeout_link_a: assert property (port_in[0].line_err_stb &&
      port_in[0].line_err_code == SBS_LERR_TIMEOUT &&
      st_r.port[0].mode == SBS_MODE_LINK_1TO1 |=> st_r.port[0].code == SBS_LERR_TIMEOUT)
    else $error("timeout code lost in one-to-one mode");
  timeout_mode_b_a: assert property (port_in[1].line_err_stb &&
      port_in[1].line_err_code == SBS_LERR_TIMEOUT &&
      st_r.port[1].mode != SBS_MODE_LINK_1TO1 && !st_r.wr_pend
      |=> st_r.port[1].code == $past(st_r.port[1].code))
    else $error("port B timeout code taken outside one-to-one mode");

  // Send ready, reception complete, overflow and abort flags
  send_rdy_a: assert property (st_r.port[0].mode == SBS_MODE_SCRIPT |-> !line_word[5])
    else $error("send ready shown in scripted mode");
  send_rdy_b_a: assert property (st_r.port[1].mode == SBS_MODE_HOST_CMD |->
      line_word[SBS_PORT_B_SHIFT+SBS_SEND_RDY_BIT] == port_in[1].send_ready)
    else $error("port B send ready wrong in host command mode");
  send_raw_a: assert property (st_r.port[0].mode == SBS_MODE_RAW |->
      line_word[SBS_SEND_RDY_BIT] == port_in[0].send_ready)
    else $error("port A send ready wrong in raw mode");
  send_rdy_lnk_a: assert property (st_r.port[1].mode == SBS_MODE_LINK_1TO1 |->
      !line_word[SBS_PORT_B_SHIFT+SBS_SEND_RDY_BIT])
    else $error("port B send ready shown in one-to-one mode");
  done_rise_a: assert property ($rose(st_r.port[0].done) |-> $past(port_in[0].rx_byte))
    else $error("port A reception complete without a byte");
  done_sticky_a: assert property (st_r.port[1].done && !st_r.wr_pend |=> st_r.port[1].done)
    else $error("port B reception complete lost");
  done_hidden_a: assert property (st_r.port[1].mode != SBS_MODE_RAW |->
      !line_word[SBS_PORT_B_SHIFT+SBS_RX_DONE_BIT])
    else $error("port B reception complete shown outside raw mode");
  ovf_rise_a: assert property ($rose(st_r.port[0].ovf) |-> $past(st_r.port[0].done))
    else $error("port A overflow before reception complete");
  ovf_sticky_a: assert property (st_r.port[0].ovf && !st_r.wr_pend |=> st_r.port[0].ovf)
    else $error("port A overflow lost");
  abort_set_a: assert property (st_r.port[1].mode == SBS_MODE_SCRIPT &&
      port_in[1].seq_abort |=> line_word[15] || st_r.port[1].mode != SBS_MODE_SCRIPT)
    else $error("port B abort not shown");
  abort_hidden_a: assert property (st_r.port[0].mode == SBS_MODE_MULTI_TERM |->
      !line_word[SBS_OVF_BIT])
    else $error("port A bit 7 shown in multi-terminal mode");

  // Counter words
  raw_count_a: assert property (st_r.port[0].mode == SBS_MODE_RAW &&
      port_in[0].rx_byte && !st_r.port[0].done && !st_r.wr_pend
      |=> st_r.port[0].rx_cnt == $past(st_r.port[0].rx_cnt) + 16'h0001)
    else $error("port A receive count did not step");
  count_hold_a: assert property (st_r.port[0].mode == SBS_MODE_RAW &&
      port_in[0].rx_byte && st_r.port[0].done && !st_r.wr_pend
      |=> st_r.port[0].rx_cnt == $past(st_r.port[0].rx_cnt))
    else $error("port A receive count moved after completion");
  raw_count_b_a: assert property (st_r.port[1].mode == SBS_MODE_RAW &&
      port_in[1].rx_byte && !st_r.port[1].done && !st_r.wr_pend
      |=> st_r.port[1].rx_cnt == $past(st_r.port[1].rx_cnt) + 16'h0001)
    else $error("port B receive count did not step");
  raw_word_b_a: assert property (st_r.port[1].mode == SBS_MODE_RAW |->
      cnt_word[1] == st_r.port[1].rx_cnt)
    else $error("port B counter word not the receive count");
  term_flags_a: assert property (st_r.port[0].mode == SBS_MODE_MULTI_TERM |->
      cnt_word[0] == {8'h00, port_in[0].term_busy})
    else $error("port A terminal flags wrong");
  term_busy_a: assert property (st_r.port[1].mode == SBS_MODE_MULTI_TERM |->
      cnt_word[1] == {8'h00, port_in[1].term_busy})
    else $error("port B terminal flags wrong");
  repeat_val_a: assert property (st_r.port[0].mode == SBS_MODE_SCRIPT |->
      cnt_word[0] == {8'h00, port_in[0].repeat_cnt})
    else $error("port A repeat counter wrong");
  repeat_val_b_a: assert property (st_r.port[1].mode == SBS_MODE_SCRIPT |->
      cnt_word[1] == {8'h00, port_in[1].repeat_cnt})
    else $error("port B repeat counter wrong");
  cnt_idle_a: assert property (st_r.port[0].mode inside
      {SBS_MODE_HOST_CMD, SBS_MODE_LINK_1TO1} |-> cnt_word[0] == SBS_WORD_RST)
    else $error("port A counter word not zero outside its modes");

  // Board fault word
  fault_hw_a: assert property (board_in.hw_err && board_in.cksum_err
      |=> st_r.fault[0] && st_r.fault[2])
    else $error("hardware or checksum fault not reported");
  fault_recog_a: assert property (board_in.recog_err |=> st_r.fault[SBS_F_RECOG_BIT])
    else $error("port recognition fault not reported");
  fault_cksum_a: assert property (board_in.cksum_err |=> st_r.fault[SBS_F_CKSUM_BIT])
    else $error("checksum fault not reported");
  fault_call_a: assert property (board_in.call_err_a |=> st_r.fault[SBS_F_CALL_A_BIT])
    else $error("port A call error not reported");
  fault_call_b_a: assert property (board_in.call_err_b |=> st_r.fault[SBS_F_CALL_B_BIT])
    else $error("port B call error not reported");
  fault_set_a: assert property (board_in.set_err_b |=> st_r.fault[15] && st_r.fault[13])
    else $error("setting error not reported");
  set_port_a_a: assert property (board_in.set_err_a |=>
      st_r.fault[SBS_F_SET_BIT] && st_r.fault[SBS_F_SET_A_BIT])
    else $error("port A setting error not reported");
  fault_rsvd_a: assert property (rd_take && addr_idx == SBS_IDX_FAULT |=>
      hrdata[10:3] == 8'h00)
    else $error("reserved fault bits not zero");

  // Bus read data and ignored writes
  rdata_upper_a: assert property (rd_take |=> hrdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
  status_write_a: assert property (st_r.wr_pend && st_r.wr_idx != SBS_IDX_CTRL_A |=>
      port_mode[0] == $past(port_mode[0]))
    else $error("port A mode changed by a foreign write");
  line_read_a: assert property (rd_take && addr_idx == SBS_IDX_LINE |=>
      hrdata[15:0] == $past(line_word))
    else $error("line error word read back wrong");

  // Main scenarios reached
  raw_done_c: cover property (st_r.port[0].mode == SBS_MODE_RAW ##1 st_r.port[0].done);
  ovf_c: cover property (line_word[SBS_OVF_BIT] && st_r.port[0].mode == SBS_MODE_RAW);
  read_c: cover property (addr_ok && !hwrite && addr_idx == SBS_IDX_LINE);
  abort_c: cover property (st_r.port[1].mode == SBS_MODE_SCRIPT && line_word[15]);
  timeout_c: cover property (st_r.port[0].code == SBS_LERR_TIMEOUT);

endmodule

// [verification/sbs_host.sv]
`timescale 1ns/1ps
// ----------------------------------------
// Host processor model on the status bus
// ----------------------------------------
module sbs_host (
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  // Idle bus at time zero
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
  end

  // One whole-word single transfer, each phase held until hready
  task automatic xfer(input logic w, input logic [9:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {20'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    hwdata <= ~wd; // No stale value on a released data bus
  endtask
endmodule

// [verification/tb_serial_board_status_words.sv]
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR %s expected %h seen %h", n, e, g); end end
module tb_serial_board_status_words import sbs_pkg::*;;
  logic hclk, hresetn, hsel, hwrite, hready, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [2:0] port_mode [2];
  sbs_port_in_t pin [2];
  sbs_board_in_t board_in;
  int error_cnt, comparisons;

  // ----------------------------------------
  // Clock, design and host
  // ----------------------------------------
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  sbs_status_bank dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .port_in(pin),
    .board_in(board_in), .port_mode(port_mode));

  sbs_host host (.hclk(hclk), .hready(hready), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [9:0] ix(int p, logic [9:0] a, logic [9:0] b);
    return p ? b : a;
  endfunction
  task automatic tick(int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic rd(input logic [9:0] i, output logic [31:0] d);
    host.xfer(1'b0, i, 32'h0, d);
    `CHK("hresp", 1'b0, hresp)
  endtask
  task automatic wr(input logic [9:0] i, input logic [31:0] v);
    logic [31:0] d;
    host.xfer(1'b1, i, v, d);
  endtask
  task automatic stb(int p, logic [3:0] c);
    pin[p].line_err_code <= c;
    pin[p].line_err_stb <= 1'b1;
    tick(1);
    pin[p].line_err_stb <= 1'b0;
    tick(2);
  endtask
  task automatic bytes(int p, int k);
    pin[p].rx_byte <= 1'b1;
    tick(k);
    pin[p].rx_byte <= 1'b0;
    tick(2);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    logic [9:0] ids [5];
    logic [31:0] d;
    ids = '{SBS_IDX_FAULT, SBS_IDX_LINE, SBS_IDX_CNT_A, SBS_IDX_CNT_B, 10'h3ff};
    foreach (ids[i]) begin
      wr(ids[i], 32'h0000_ffff);
      rd(ids[i], d);
      `CHK("status_word", 32'h0, d)
    end
  endtask

  task automatic t_fault;
    logic [15:0] exp [8];
    logic [31:0] d;
    exp = '{16'h0001, 16'h0002, 16'h0004, 16'h1000, 16'h0800, 16'hc000, 16'ha000, 16'hf807};
    for (int b = 0; b < 8; b++) begin
      board_in <= sbs_board_in_t'(b == 7 ? 7'h7f : 7'h40 >> b);
      tick(2);
      rd(SBS_IDX_FAULT, d);
      `CHK("fault_word", {16'h0, exp[b]}, d)
    end
    board_in <= '0;
  endtask

  task automatic t_line;
    logic [31:0] d;
    pin[0].send_ready <= 1'b1;
    pin[1].send_ready <= 1'b1;
    for (int p = 0; p < 2; p++) begin
      for (int c = 1; c < 5; c++) begin
        stb(p, c[3:0]);
        rd(SBS_IDX_LINE, d);
        `CHK("line_byte", (c == 4) ? 8'h33 : 8'h30 | c[7:0], d[8*p +: 8])
      end
      wr(ix(p, SBS_IDX_CTRL_A, SBS_IDX_CTRL_B), 32'h3);
      stb(p, 4'h4);
      `CHK("mode_out", 3'h3, port_mode[p])
      rd(SBS_IDX_LINE, d);
      `CHK("line_timeout", 8'h14, d[8*p +: 8])
      stb(p, 4'h0);
      wr(ix(p, SBS_IDX_CTRL_A, SBS_IDX_CTRL_B), 32'h0);
    end
  endtask

  task automatic t_raw;
    logic [31:0] d;
    logic [7:0] fl [3];
    int n;
    fl = '{8'h20, 8'h60, 8'he0};
    for (int p = 0; p < 2; p++) begin
      n = p ? 256 : 2;
      wr(ix(p, SBS_IDX_CTRL_A, SBS_IDX_CTRL_B), p ? 32'h0001 : 32'h0201);
      for (int k = 0; k < 3; k++) begin
        bytes(p, k ? 1 : n - 1);
        rd(ix(p, SBS_IDX_CNT_A, SBS_IDX_CNT_B), d);
        `CHK("rx_count", 32'(k ? n : n - 1), d)
        rd(SBS_IDX_LINE, d);
        `CHK("raw_flags", fl[k], d[8*p +: 8])
      end
      wr(ix(p, SBS_IDX_CTRL_A, SBS_IDX_CTRL_B), p ? 32'h0011 : 32'h0211);
      rd(ix(p, SBS_IDX_CNT_A, SBS_IDX_CNT_B), d);
      `CHK("rx_restart", 32'h0, d)
      rd(SBS_IDX_LINE, d);
      `CHK("raw_cleared", 8'h20, d[8*p +: 8])
    end
  endtask

  task automatic t_script;
    logic [31:0] d;
    for (int p = 0; p < 2; p++) begin
      pin[p].repeat_cnt <= p ? 8'ha5 : 8'h5a;
      pin[p].term_busy <= p ? 8'h81 : 8'h3c;
      wr(ix(p, SBS_IDX_CTRL_A, SBS_IDX_CTRL_B), 32'h2);
      pin[p].seq_abort <= 1'b1;
      tick(1);
      pin[p].seq_abort <= 1'b0;
      tick(2);
      rd(ix(p, SBS_IDX_CNT_A, SBS_IDX_CNT_B), d);
      `CHK("repeat_cnt", p ? 32'ha5 : 32'h5a, d)
      rd(SBS_IDX_LINE, d);
      `CHK("abort_flag", 8'h80, d[8*p +: 8])
      wr(ix(p, SBS_IDX_CTRL_A, SBS_IDX_CTRL_B), 32'h4);
      rd(ix(p, SBS_IDX_CNT_A, SBS_IDX_CNT_B), d);
      `CHK("term_busy", p ? 32'h81 : 32'h3c, d)
      `CHK("mode_out", 3'h4, port_mode[p])
      rd(SBS_IDX_LINE, d);
      `CHK("hidden_flags", 8'h00, d[8*p +: 8])
      wr(ix(p, SBS_IDX_CTRL_A, SBS_IDX_CTRL_B), 32'h10);
    end
  endtask

  // ----------------------------------------
  // Verdict, main sequence and watchdog
  // ----------------------------------------
  task automatic test_done;
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Reset for 20 cycles, then every scenario in turn
  initial begin
    error_cnt = 0;
    comparisons = 0;
    hresetn = 1'b0;
    board_in = '0;
    pin[0] = '0;
    pin[1] = '0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_fault;
    t_line;
    t_raw;
    t_script;
    test_done;
  end

  // Whole run needs about 550 cycles; allow 20000
  initial begin
    #(50 * 20000);
    error_cnt++;
    test_done;
  end
endmodule
